//--- logic/sle_defines.svh
/*
 holds the constants of the status lamp and error policy block.
 assumes it is included by bare name from the flash and status design files.
*/
`ifndef SLE_DEFINES_SVH
`define SLE_DEFINES_SVH

`define SLE_CLK_HZ        25000000
`define SLE_FLASH_MS      250
`define SLE_FLASH_CYC     ((`SLE_CLK_HZ / 1000) * `SLE_FLASH_MS)
`define SLE_ERR_W         8
`define SLE_ERR_SYNTAX    0
`define SLE_ERR_DUPOUT    1
`define SLE_ERR_IOVERIFY  2
`define SLE_ERR_CALC      3
`define SLE_ERR_BATTERY   4
`define SLE_ERR_LINK      5
// adapter power-order decision: taken once, when the two-stage
// synchroniser first shows real pin levels after reset
`define SLE_BOOT_DECIDE   2'h2
`define SLE_BOOT_DONE     2'h3

`endif

//--- logic/sle_pkg.sv
/*
 holds the types of the status lamp and error policy block.
 assumes sle_defines.svh is available.
*/
`default_nettype none
package sle_pkg;

  // configuration items that choose stop or continue, or whether an error is recorded
  typedef struct packed {
    logic dup_out_chk;   // item 20: duplicated output counts as error
    logic stop_iover;    // item 23: stop on i/o verification error
    logic stop_calc;     // item 26: stop on calculation error
    logic batt_alarm;    // item 4: battery error raises alarm
  } sle_cfg_s;

  typedef struct packed {
    logic run_lamp;
    logic edit_mode_lamp;
    logic fault_lamp;
  } sle_main_lamp_s;

  typedef struct packed {
    logic supply_lamp;
    logic link_lamp;
    logic fault_lamp;
  } sle_exp_lamp_s;

  typedef enum logic [3:0] {
    SLE_EXP_IDLE  = 4'h1,
    SLE_EXP_UP    = 4'h2,
    SLE_EXP_FAULT = 4'h4,
    SLE_EXP_LATE  = 4'h8
  } sle_exp_e;

endpackage
`default_nettype wire

//--- logic/sle_flash.sv
/*
 holds the shared flash phase generator.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sle_defines.svh"

module sle_flash #(
  parameter int unsigned FLASH_CYC = `SLE_FLASH_CYC
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  output var  logic phase
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        phase_r;
  logic        phase_nxt;

  always_comb begin
    cnt_nxt   = cnt_r + 32'h1;
    phase_nxt = phase_r;
    if (cnt_r >= FLASH_CYC - 1) begin
      cnt_nxt   = 32'h0;
      phase_nxt = ~phase_r; // R15
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r   <= 32'h0;
      phase_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

endmodule // sle_flash
`default_nettype wire

//--- logic/sle_sync.sv
/*
 holds a two flip-flop synchroniser for a bus of pin levels.
 assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module sle_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule // sle_sync
`default_nettype wire

//--- logic/sle_status.sv
/*
 holds the status lamp driver and error stop policy of the controller,
 plus the expansion adapter lamp decoder.
 assumes all inputs except the configuration come from pins and are
 synchronised here; cfg is static logic on clk_sys.
 a pin change reaches the outputs on the third edge, cfg on the first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sle_defines.svh"

// Operation
// R1 - self-diagnostic check detects errors and halts execution where needed
// R2 - any error stops execution unless its flag selects continue; here a battery error never stops
// R3 - a subset of errors read a per-error stop or continue setting
// R4 - program mode: edit lamp steady, others off, halted, no flashing
// R5 - forced i/o in run: run and edit lamps alternate, keep running
// R6 - diag error flashes fault; run lamp if running, edit lamp if halted
// R7 - watchdog trip: fault lamp steady, execution stops
// R8 - item 20 cleared: duplicated output is no error
// R9 - item 26 cleared: calculation error continues yet stays recorded
// R10 - item 23 selects stop on i/o verification error
// R11 - item 4 selects whether battery error raises alarm
// R12 - no expansion unit: supply on, link flashes, fault off
// R13 - unit lost or link error: fault flashes, supply and link on
// R14 - adapter powered after controller: supply on, link and fault off
// R15 - one parameterised flash period; alternate flashing in opposite phase
// R16 - watchdog beats diag error, which beats forced i/o
module sle_status #(
  parameter int unsigned FLASH_CYC = `SLE_FLASH_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire sle_pkg::sle_cfg_s      cfg,
  input  wire logic                   run_sel,
  input  wire logic                   force_act,
  input  wire logic                   wdog_trip,
  input  wire logic [`SLE_ERR_W-1:0]  err_evt,
  input  wire logic                   err_clr,
  input  wire logic                   exp_present,
  input  wire logic                   exp_link_err,
  input  wire logic                   exp_late_pwr,
  output var  logic                   exec_en,
  output var  logic                   diag_err,
  output var  logic [`SLE_ERR_W-1:0]  err_flags,
  output var  sle_pkg::sle_main_lamp_s main_lamp,
  output var  sle_pkg::sle_exp_lamp_s  exp_lamp
);

  localparam int unsigned NIN = `SLE_ERR_W + 7;

  // stop-or-continue decision for each error code
  function automatic logic err_stops(input int unsigned idx,
                                     input sle_pkg::sle_cfg_s c);
    unique case (idx)
      // codes without a policy item always halt
      `SLE_ERR_SYNTAX:   err_stops = 1'b1;           // R2
      `SLE_ERR_DUPOUT:   err_stops = 1'b1;           // R2
      `SLE_ERR_LINK:     err_stops = 1'b1;           // R2
      `SLE_ERR_IOVERIFY: err_stops = c.stop_iover;   // R10 R3
      `SLE_ERR_CALC:     err_stops = c.stop_calc;    // R9 R3
      // a battery fault only warns; the program keeps running
      `SLE_ERR_BATTERY:  err_stops = 1'b0;
      default:           err_stops = 1'b1;           // R2
    endcase
  endfunction

  logic [NIN-1:0]          pin_raw;
  logic [NIN-1:0]          pin_s;
  logic                    run_s;
  logic                    force_s;
  logic                    wdog_s;
  logic [`SLE_ERR_W-1:0]   evt_s;
  logic                    clr_s;
  logic                    pres_s;
  logic                    lerr_s;
  logic                    late_s;
  logic                    phase;

  assign pin_raw = {run_sel, force_act, wdog_trip, err_evt, err_clr,
                    exp_present, exp_link_err, exp_late_pwr};
  assign {run_s, force_s, wdog_s, evt_s, clr_s, pres_s, lerr_s, late_s} =
    pin_s;

  // all pins pass the same two stages, so levels that change together
  // reach the logic together; cfg is already on clk_sys and skips them
  sle_sync #(.W(NIN)) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (pin_raw),
    .q       (pin_s)
  );

  sle_flash #(.FLASH_CYC(FLASH_CYC)) u_flash (
    .clk_sys (clk_sys),
    .srst    (srst),
    .phase   (phase)
  );

  // error recording and stop policy
  logic [`SLE_ERR_W-1:0] flags_r;
  logic [`SLE_ERR_W-1:0] flags_nxt;
  logic [`SLE_ERR_W-1:0] evt_q;
  logic [`SLE_ERR_W-1:0] stop_mask;
  logic                  halt_nxt;
  logic                  wdog_r;
  logic                  wdog_nxt;
  logic                  diag_nxt;

  // policy bits are not latched: a cfg change takes effect on the next
  // edge, even for errors that are already recorded
  for (genvar g = 0; g < `SLE_ERR_W; g++) begin : g_stop
    assign stop_mask[g] = err_stops(g, cfg);         // R2 R3 R10
  end

  always_comb begin
    evt_q = evt_s;
    if (!cfg.dup_out_chk)
      evt_q[`SLE_ERR_DUPOUT] = 1'b0;                 // R8
    if (!cfg.batt_alarm)
      evt_q[`SLE_ERR_BATTERY] = 1'b0;                // R11
    // a new event wins over a clear in the same cycle
    flags_nxt = (clr_s ? '0 : flags_r) | evt_q;      // R1 R9
    // halt follows the flags, so clearing the errors resumes execution
    halt_nxt = |(flags_nxt & stop_mask);             // R1 R2 R3
    // watchdog latches until reset; only a restart clears it
    wdog_nxt = wdog_r | wdog_s;                      // R7
    diag_nxt = |flags_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_r <= '0;
      wdog_r  <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      wdog_r  <= wdog_nxt;
    end
  end

  // main lamps and execution enable
  // built from the next flag values, so lamps, exec_en and err_flags
  // move on one edge; priority runs watchdog, diag error, program mode,
  // forced i/o
  sle_pkg::sle_main_lamp_s lamp_r;
  sle_pkg::sle_main_lamp_s lamp_nxt;
  logic                    exec_r;
  logic                    exec_nxt;
  logic                    diag_r;

  always_comb begin
    lamp_nxt = '0;
    exec_nxt = 1'b0;
    if (wdog_nxt) begin
      lamp_nxt.fault_lamp = 1'b1;                    // R7 R16
      exec_nxt = 1'b0;
    end else if (diag_nxt) begin
      lamp_nxt.fault_lamp = phase;                   // R6 R16
      if (halt_nxt || !run_s) begin
        lamp_nxt.edit_mode_lamp = 1'b1;              // R6
      end else begin
        lamp_nxt.run_lamp = 1'b1;                    // R6
        exec_nxt = 1'b1;
      end
    end else if (!run_s) begin
      lamp_nxt.edit_mode_lamp = 1'b1;                // R4
    end else if (force_s) begin
      lamp_nxt.run_lamp       = phase;               // R5 R15
      lamp_nxt.edit_mode_lamp = ~phase;              // R5 R15
      exec_nxt = 1'b1;
    end else begin
      lamp_nxt.run_lamp = 1'b1;
      exec_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lamp_r <= '0;
      exec_r <= 1'b0;
      diag_r <= 1'b0;
    end else begin
      lamp_r <= lamp_nxt;
      exec_r <= exec_nxt;
      diag_r <= diag_nxt;
    end
  end

  // expansion adapter lamps
  sle_pkg::sle_exp_e      est_r;
  sle_pkg::sle_exp_e      est_nxt;
  sle_pkg::sle_exp_lamp_s elamp_r;
  sle_pkg::sle_exp_lamp_s elamp_nxt;
  // counts edges after reset until the synchronised pins are valid
  logic [1:0]             boot_r;
  logic [1:0]             boot_nxt;

  always_comb begin
    est_nxt  = est_r;
    boot_nxt = boot_r;
    if (boot_r != `SLE_BOOT_DONE)
      boot_nxt = boot_r + 2'h1;
    unique case (est_r)
      sle_pkg::SLE_EXP_IDLE: begin
        // the synchroniser shows reset zeros for its first edges, so the
        // power-order decision waits for real pin levels, and is taken once
        if (boot_r == `SLE_BOOT_DECIDE && late_s)
          est_nxt = sle_pkg::SLE_EXP_LATE;           // R14
        else if (boot_r == `SLE_BOOT_DECIDE && pres_s)
          est_nxt = sle_pkg::SLE_EXP_UP;
        else if (lerr_s)
          est_nxt = sle_pkg::SLE_EXP_FAULT;
      end
      sle_pkg::SLE_EXP_UP: begin
        if (!pres_s || lerr_s)
          est_nxt = sle_pkg::SLE_EXP_FAULT;          // R13
      end
      sle_pkg::SLE_EXP_FAULT: est_nxt = est_r;       // held until reset
      sle_pkg::SLE_EXP_LATE:  est_nxt = est_r;
      default:                est_nxt = sle_pkg::SLE_EXP_IDLE;
    endcase
    elamp_nxt.supply_lamp = 1'b1;
    elamp_nxt.link_lamp   = 1'b0;
    elamp_nxt.fault_lamp  = 1'b0;
    unique case (est_nxt)
      sle_pkg::SLE_EXP_IDLE:  elamp_nxt.link_lamp = phase;  // R12
      sle_pkg::SLE_EXP_UP:    elamp_nxt.link_lamp = 1'b1;
      sle_pkg::SLE_EXP_FAULT: begin
        elamp_nxt.link_lamp  = 1'b1;                 // R13
        elamp_nxt.fault_lamp = phase;                // R13
      end
      default:                elamp_nxt.link_lamp = 1'b0;   // R14
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      est_r   <= sle_pkg::SLE_EXP_IDLE;
      elamp_r <= '0;
      boot_r  <= 2'h0;
    end else begin
      est_r   <= est_nxt;
      elamp_r <= elamp_nxt;
      boot_r  <= boot_nxt;
    end
  end

  assign exec_en   = exec_r;
  assign diag_err  = diag_r;
  assign err_flags = flags_r;
  assign main_lamp = lamp_r;
  assign exp_lamp  = elamp_r;

endmodule // sle_status
`default_nettype wire

//--- dv/sle_status_asserts.sv
/* checker for the status lamp block.
   assumes it is bound to sle_status and pins reach lamps in 3 edges. */
`timescale 1ns/1ps
`default_nettype none
module sle_status_asserts #(
  parameter int unsigned FLASH_CYC = 4
) (
  input wire logic                    clk_sys,
  input wire logic                    srst,
  input wire sle_pkg::sle_cfg_s       cfg,
  input wire logic                    run_sel,
  input wire logic                    force_act,
  input wire logic                    wdog_trip,
  input wire logic [7:0]              err_evt,
  input wire logic                    err_clr,
  input wire logic                    exp_present,
  input wire logic                    exp_link_err,
  input wire logic                    exp_late_pwr,
  input wire logic                    exec_en,
  input wire logic                    diag_err,
  input wire logic [7:0]              err_flags,
  input wire sle_pkg::sle_main_lamp_s main_lamp,
  input wire sle_pkg::sle_exp_lamp_s  exp_lamp
);
  logic [2:0] cnt_r;
  logic       wd_r;
  logic       ok;
  // pipeline must hold post-reset values before $past is trusted
  always_ff @(posedge clk_sys) begin
    cnt_r <= srst ? 3'h0 : cnt_r + {2'h0, cnt_r != 3'h4};
    wd_r  <= !srst && (wd_r || wdog_trip);
  end
  assign ok = cnt_r == 3'h4 && !wd_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence fault_hold;
    main_lamp.fault_lamp [*4];
  endsequence
  a_wdog_stop:
    assert property (cnt_r == 3'h4 && $past(wdog_trip, 3) |-> fault_hold
      and !exec_en [*4]) else $error("watchdog lamp wrong");
  a_edit_mode_lamp_mode:
    assert property (ok && !diag_err && !$past(diag_err)
      && !$past(run_sel, 3) |-> main_lamp == 3'h2 && !exec_en)
      else $error("program mode lamps wrong");
  a_force_alt:
    assert property (ok && !diag_err && !$past(diag_err) && $past(run_sel, 3)
      && $past(force_act, 3) |-> main_lamp.run_lamp
      != main_lamp.edit_mode_lamp && !main_lamp.fault_lamp && exec_en)
      else $error("forced lamps wrong");
  a_err_halt:
    assert property (ok && $past(err_evt[0], 3) |-> err_flags[0] && diag_err
      && !exec_en && main_lamp.edit_mode_lamp && !main_lamp.run_lamp)
      else $error("error did not halt");
  a_iover_sel:
    assert property (ok && err_flags == 8'h04 && $stable(err_flags)
      && $stable(cfg) && $past(run_sel, 3) && $past(run_sel, 4)
      |-> exec_en == !cfg.stop_iover) else $error("verify policy wrong");
  a_dup_gate:
    assert property ($rose(err_flags[1]) |-> $past(cfg.dup_out_chk))
      else $error("duplicate output flagged");
  a_batt_gate:
    assert property ($rose(err_flags[4]) |-> $past(cfg.batt_alarm))
      else $error("battery flagged");
  a_exp_supply:
    assert property (cnt_r == 3'h4 |-> exp_lamp.supply_lamp)
      else $error("supply lamp off");
  sequence exp_blink;
    exp_lamp.link_lamp ##[1:9] !exp_lamp.fault_lamp
      ##[1:9] exp_lamp.fault_lamp;
  endsequence
  a_exp_fault:
    assert property (cnt_r == 3'h4 && $past(exp_link_err, 3)
      && !$past(exp_late_pwr, 3) |-> exp_blink)
      else $error("link fault not flashing");
endmodule // sle_status_asserts
`default_nettype wire

//--- dv/sle_exp_model.sv
/* expansion unit model: presence, power order and link error pins.
   assumes the bench commands it at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module sle_exp_model (
  input  wire logic attach,
  input  wire logic late,
  input  wire logic noise,
  output var  logic exp_present,
  output var  logic exp_late_pwr,
  output var  logic exp_link_err
);
  // a late unit is still attached; noise only hits a live link
  assign exp_present  = attach || late;
  assign exp_late_pwr = late;
  assign exp_link_err = noise && attach;
endmodule // sle_exp_model
`default_nettype wire

//--- dv/sle_status_tb.sv
/* bench for sle_status: lamp states, error policy table, adapter lamps.
   assumes FLASH_CYC of 4 and three edges from pin to output. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module sle_status_tb;
  localparam int unsigned FC = 4;
  logic clk_sys = 1'b0, srst = 1'b1, run_sel = 1'b1, force_act = 1'b0;
  logic wdog_trip = 1'b0, err_clr = 1'b0, attach = 1'b0;
  logic late = 1'b0, noise = 1'b0;
  logic exp_present, exp_link_err, exp_late_pwr, exec_en, diag_err;
  logic [7:0] err_evt = 8'h00;
  logic [7:0] err_flags;
  logic [5:0] lamps;
  sle_pkg::sle_cfg_s cfg = '0;
  sle_pkg::sle_main_lamp_s main_lamp;
  sle_pkg::sle_exp_lamp_s exp_lamp;
  int compares = 0, n_mismatch = 0;
  // {bit, cfg, flag, exec}
  logic [8:0] tbl [9] = '{9'h002, 9'h041, 9'h062, 9'h092, 9'h083,
                          9'h0CA, 9'h0C3, 9'h101, 9'h107};
  assign lamps = {main_lamp, exp_lamp};
  sle_status #(.FLASH_CYC(FC)) dut (.clk_sys(clk_sys), .srst(srst),
    .cfg(cfg), .run_sel(run_sel), .force_act(force_act),
    .wdog_trip(wdog_trip), .err_evt(err_evt), .err_clr(err_clr),
    .exp_present(exp_present), .exp_link_err(exp_link_err),
    .exp_late_pwr(exp_late_pwr), .exec_en(exec_en), .diag_err(diag_err),
    .err_flags(err_flags), .main_lamp(main_lamp), .exp_lamp(exp_lamp));
  sle_exp_model u_exp (.attach(attach), .late(late), .noise(noise),
    .exp_present(exp_present), .exp_late_pwr(exp_late_pwr),
    .exp_link_err(exp_link_err));
  initial forever #20 clk_sys = ~clk_sys;
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic boot(input logic a, input logic l);
    srst = 1'b1; attach = a; late = l;
    w(12);
    srst = 1'b0;
    w(6);
  endtask
  task automatic flash(input int b, input logic on);
    logic a;
    a = lamps[b];
    w(FC);
    `CHK("flash", on, lamps[b] !== a)
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40 * 3000);
    n_mismatch++;
    complete_run;
  end
  initial begin
    boot(1'b1, 1'b0);
    `CHK("norm", 6'h26, lamps)
    run_sel = 1'b0; force_act = 1'b1; w(5);
    `CHK("edit_mode_lamp", 6'h16, lamps)
    flash(4, 1'b0);
    run_sel = 1'b1; w(5);
    `CHK("alt", 1'b1, lamps[5] ^ lamps[4])
    `CHK("exec", 1'b1, exec_en)
    flash(5, 1'b1);
    err_evt = 8'h01; w(1); err_evt = 8'h00; w(4);
    `CHK("prio", 2'h1, lamps[5:4])
    flash(3, 1'b1);
    err_clr = 1'b1; force_act = 1'b0; w(1); err_clr = 1'b0; w(4);
    $display("test lamps done");
    foreach (tbl[i]) begin
      cfg = tbl[i][5:2];
      err_evt = 8'h01 << tbl[i][8:6];
      w(1);
      err_evt = 8'h00;
      w(4);
      `CHK("flags", {7'h0, tbl[i][1]} << tbl[i][8:6], err_flags)
      `CHK("diag", tbl[i][1], diag_err)
      `CHK("exec", tbl[i][0], exec_en)
      `CHK("run", tbl[i][0], lamps[5])
      err_clr = 1'b1; w(1); err_clr = 1'b0; w(4);
    end
    $display("test policy done");
    noise = 1'b1; w(1); noise = 1'b0; w(4);
    `CHK("xfault", 2'h3, lamps[2:1])
    flash(0, 1'b1);
    wdog_trip = 1'b1; w(1); wdog_trip = 1'b0; w(4);
    `CHK("wdog", 2'h2, {lamps[3], exec_en})
    flash(3, 1'b0);
    boot(1'b0, 1'b0);
    `CHK("idle", 2'h2, {lamps[2], lamps[0]})
    flash(1, 1'b1);
    boot(1'b1, 1'b1);
    `CHK("late", 3'h4, lamps[2:0])
    flash(1, 1'b0);
    boot(1'b1, 1'b0);
    `CHK("up", 3'h6, lamps[2:0])
    attach = 1'b0; w(5);
    `CHK("lost", 2'h3, lamps[2:1])
    flash(0, 1'b1);
    $display("test adapter done");
    complete_run;
  end
endmodule // sle_status_tb
bind sle_status sle_status_asserts #(.FLASH_CYC(FLASH_CYC)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .cfg(cfg), .run_sel(run_sel),
  .force_act(force_act), .wdog_trip(wdog_trip), .err_evt(err_evt),
  .err_clr(err_clr), .exp_present(exp_present),
  .exp_link_err(exp_link_err), .exp_late_pwr(exp_late_pwr),
  .exec_en(exec_en), .diag_err(diag_err), .err_flags(err_flags),
  .main_lamp(main_lamp), .exp_lamp(exp_lamp));
`default_nettype wire
